// >>> logic/monitor_mailbox_serial_link.sv
`timescale 1ns/100ps
module monitor_mailbox_serial_link
  import mon_mailbox_pkg::*;
(
  input  wire logic                   CLK,
  input  wire logic                   SRST,
  input  wire logic                   CE,
  input  wire logic                   CMD_WR,
  input  wire logic                   DATA_WR,
  input  wire logic [7:0]             HOST_WDATA,
  input  wire logic                   HOST_RD,
  output logic                        CMD_CONSUMED,
  output logic                        DATA_CONSUMED,
  output mon_mailbox_pkg::byte_type   HOST_RESP,
  input  wire logic                   RXD,
  output logic                        TXD,
  input  wire logic                   CTS,
  output logic                        RTS,
  input  wire logic                   DCD,
  input  wire logic                   RING,
  input  wire logic                   DIAL_REQ,
  output logic                        DIAL_ALLOWED,
  output logic                        ANSWER,
  output logic [7:0]                  MAILBOX
);
  import mon_mailbox_pkg::*;

  // Whole scratchpad; four of its blocks hold one full 32-byte payload
  logic [7:0]  spad_mem [SPAD_BLOCKS*SPAD_BLOCK_BYTES];
  logic [7:0]  mbox_ff;
  logic [15:0] rx_cnt_ff;
  logic [3:0]  rx_bit_ff;
  logic [7:0]  rx_sh_ff;
  logic        rx_busy_ff;
  byte_type    rx_byte_ff;
  logic [15:0] tx_cnt_ff;
  logic [3:0]  tx_bit_ff;
  logic [9:0]  tx_sh_ff;
  logic        tx_busy_ff;
  logic [7:0]  tx_q_ff [SPAD_BLOCK_BYTES];
  logic [3:0]  tx_qn_ff;
  logic [3:0]  tx_qi_ff;
  logic        cmd_ff, data_ff;
  logic        ser_cmd_ff;
  logic        ser_data_ff;

  // Serial frame receiver: start, 8 data LSB first, one stop
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rx_cnt_ff  <= 16'h0000;
      rx_bit_ff  <= 4'h0;
      rx_sh_ff   <= 8'h00;
      rx_busy_ff <= 1'b0;
      rx_byte_ff <= '0;
    end else if (CE) begin
      rx_byte_ff.valid <= 1'b0;
      if (!rx_busy_ff) begin
        if (!RXD) begin
          rx_busy_ff <= 1'b1;
          rx_cnt_ff  <= 16'(HALF_CYCLES);
          rx_bit_ff  <= 4'h0;
        end
      end else if (rx_cnt_ff != 16'h0000) begin
        rx_cnt_ff <= rx_cnt_ff - 16'h0001;
      end else begin
        rx_cnt_ff <= 16'(BIT_CYCLES - 1);
        rx_bit_ff <= rx_bit_ff + 4'h1;
        if (rx_bit_ff == 4'h0) begin
          if (RXD) rx_busy_ff <= 1'b0; // False start glitch
        end else if (rx_bit_ff <= 4'(DATA_BITS)) begin
          rx_sh_ff <= {RXD, rx_sh_ff[7:1]};
        end else begin
          rx_busy_ff <= 1'b0;
          // Byte taken only with a valid stop bit, no parity slot
          if (RXD) rx_byte_ff <= '{valid: 1'b1, data: rx_sh_ff};
        end
      end
    end
  end

  // RTS is asserted while the receiver is idle and drops only for the last data bit and the stop bit of a frame
  assign RTS = !rx_busy_ff || (rx_bit_ff < 4'(DATA_BITS));

  // Dial gate and call answering
  assign DIAL_ALLOWED = DIAL_REQ && !DCD;
  always_ff @(posedge CLK) begin
    if (SRST) ANSWER <= 1'b0;
    else if (CE) ANSWER <= RING || (ANSWER && !DCD) || (ANSWER && DCD && RING);
  end

  // Host byte handshake: flags set when the command engine takes a byte
  logic host_cmd_take, host_data_take, ser_take;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      CMD_CONSUMED  <= 1'b1;
      DATA_CONSUMED <= 1'b1;
      cmd_ff        <= 1'b0;
      data_ff       <= 1'b0;
    end else if (CE) begin
      if (CMD_WR) begin
        CMD_CONSUMED <= 1'b0;
        cmd_ff       <= 1'b1;
      end else if (host_cmd_take) begin
        CMD_CONSUMED <= 1'b1;
        cmd_ff       <= 1'b0;
      end
      if (DATA_WR) begin
        DATA_CONSUMED <= 1'b0;
        data_ff       <= 1'b1;
      end else if (host_data_take) begin
        DATA_CONSUMED <= 1'b1;
        data_ff       <= 1'b0;
      end
    end
  end

  // Two command engines, one for host port and one for serial port
  cmd_state_type hst_ff, sst_ff;
  logic [7:0]    h_blk_ff, s_blk_ff;
  logic [3:0]    h_idx_ff, s_idx_ff;
  logic          h_mb_we, s_mb_we, h_sp_we, s_sp_we;
  logic [7:0]    s_arg;
  logic [3:0]    h_rsp_idx_ff;

  assign s_arg = rx_byte_ff.data;
  assign host_cmd_take  = cmd_ff && (hst_ff == CP_IDLE);
  assign host_data_take = data_ff && (hst_ff == CP_MBWR || hst_ff == CP_BLK || hst_ff == CP_SWR);
  assign h_mb_we = data_ff && hst_ff == CP_MBWR;
  assign s_mb_we = rx_byte_ff.valid && sst_ff == CP_MBWR;
  assign h_sp_we = data_ff && hst_ff == CP_SWR;
  assign s_sp_we = rx_byte_ff.valid && sst_ff == CP_SWR;
  assign ser_take = rx_byte_ff.valid;

  // Host command sequencing; data byte latched at DATA_WR time
  logic [7:0] h_data_ff;
  logic       h_wr_ff;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      hst_ff        <= CP_IDLE;
      h_blk_ff      <= 8'h00;
      h_idx_ff      <= 4'h0;
      h_data_ff     <= 8'h00;
      h_wr_ff       <= 1'b0;
      HOST_RESP     <= '0;
      h_rsp_idx_ff  <= 4'h0;
    end else if (CE) begin
      if (DATA_WR || CMD_WR) h_data_ff <= HOST_WDATA;
      if (HOST_RD) HOST_RESP.valid <= 1'b0;
      case (hst_ff)
        CP_IDLE: begin
          if (cmd_ff) begin
            case (h_data_ff)
              CMD_MBOX_WR: hst_ff <= CP_MBWR;
              CMD_MBOX_RD: begin
                HOST_RESP <= '{valid: 1'b1, data: mbox_ff};
              end
              CMD_SPAD_WR: begin
                h_wr_ff <= 1'b1;
                hst_ff  <= CP_BLK;
              end
              CMD_SPAD_RD: begin
                h_wr_ff <= 1'b0;
                hst_ff  <= CP_BLK;
              end
              default: hst_ff <= CP_IDLE;
            endcase
          end
        end
        CP_MBWR: if (data_ff) hst_ff <= CP_IDLE;
        CP_BLK: begin
          if (data_ff) begin
            h_blk_ff <= h_data_ff & BLOCK_MAX;
            h_idx_ff <= 4'h0;
            h_rsp_idx_ff <= 4'h0;
            hst_ff   <= h_wr_ff ? CP_SWR : CP_RESP;
          end
        end
        CP_SWR: begin
          if (data_ff) begin
            h_idx_ff <= h_idx_ff + 4'h1;
            if (h_idx_ff == 4'(SPAD_BLOCK_BYTES - 1)) hst_ff <= CP_IDLE;
          end
        end
        CP_RESP: begin
          // One byte presented at a time; host read advances it
          if (!HOST_RESP.valid || HOST_RD) begin
            HOST_RESP <= '{valid: 1'b1, data: spad_mem[{h_blk_ff[4:0], h_rsp_idx_ff[2:0]}]};
            h_rsp_idx_ff <= h_rsp_idx_ff + 4'h1;
            if (h_rsp_idx_ff == 4'(SPAD_BLOCK_BYTES - 1)) hst_ff <= CP_IDLE;
          end
        end
        default: hst_ff <= CP_IDLE;
      endcase
    end
  end

  // Serial command sequencing; replies queued into the transmitter
  logic       s_wr_ff;
  logic       s_q_load;
  logic [3:0] s_q_n;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sst_ff   <= CP_IDLE;
      s_blk_ff <= 8'h00;
      s_idx_ff <= 4'h0;
      s_wr_ff  <= 1'b0;
    end else if (CE && ser_take) begin
      case (sst_ff)
        CP_IDLE: begin
          case (s_arg)
            CMD_MBOX_WR: sst_ff <= CP_MBWR;
            CMD_SPAD_WR: begin
              s_wr_ff <= 1'b1;
              sst_ff  <= CP_BLK;
            end
            CMD_SPAD_RD: begin
              s_wr_ff <= 1'b0;
              sst_ff  <= CP_BLK;
            end
            default: sst_ff <= CP_IDLE;
          endcase
        end
        CP_MBWR: sst_ff <= CP_IDLE;
        CP_BLK: begin
          s_blk_ff <= s_arg & BLOCK_MAX;
          s_idx_ff <= 4'h0;
          sst_ff   <= s_wr_ff ? CP_SWR : CP_IDLE;
        end
        CP_SWR: begin
          s_idx_ff <= s_idx_ff + 4'h1;
          if (s_idx_ff == 4'(SPAD_BLOCK_BYTES - 1)) sst_ff <= CP_IDLE;
        end
        default: sst_ff <= CP_IDLE;
      endcase
    end
  end

  // Queue still holds bytes not yet handed to the transmitter
  logic tx_busy_q;
  assign tx_busy_q = (tx_qi_ff != tx_qn_ff);

  // Replies: read mailbox gives one byte, block read gives eight
  assign s_q_load = CE && ser_take && !tx_busy_q &&
                    ((sst_ff == CP_IDLE && s_arg == CMD_MBOX_RD) || (sst_ff == CP_BLK && !s_wr_ff));
  assign s_q_n = (sst_ff == CP_IDLE) ? 4'h1 : 4'(SPAD_BLOCK_BYTES);

  // Mailbox: host write wins a same-cycle tie since it completed later in its sequence
  always_ff @(posedge CLK) begin
    if (SRST) mbox_ff <= MBOX_IDLE;
    else if (CE) begin
      if (h_mb_we) mbox_ff <= h_data_ff;
      else if (s_mb_we) mbox_ff <= s_arg;
    end
  end
  assign MAILBOX = mbox_ff;

  // Scratchpad shared by both ports; no reset so it maps to RAM
  always_ff @(posedge CLK) begin
    if (CE) begin
      if (h_sp_we) spad_mem[{h_blk_ff[4:0], h_idx_ff[2:0]}] <= h_data_ff;
      else if (s_sp_we) spad_mem[{s_blk_ff[4:0], s_idx_ff[2:0]}] <= s_arg;
    end
  end

  // Transmit queue and UART; each frame waits for CTS before its start bit
  always_ff @(posedge CLK) begin
    if (SRST) begin
      tx_cnt_ff  <= 16'h0000;
      tx_bit_ff  <= 4'h0;
      tx_sh_ff   <= 10'h3FF;
      tx_busy_ff <= 1'b0;
      tx_qn_ff   <= 4'h0;
      tx_qi_ff   <= 4'h0;
      for (int i = 0; i < SPAD_BLOCK_BYTES; i++) tx_q_ff[i] <= 8'h00;
    end else if (CE) begin
      if (s_q_load) begin
        tx_qi_ff <= 4'h0;
        tx_qn_ff <= s_q_n;
        if (sst_ff == CP_IDLE) tx_q_ff[0] <= mbox_ff;
        else for (int i = 0; i < SPAD_BLOCK_BYTES; i++)
          tx_q_ff[i] <= spad_mem[{s_arg[4:0], 3'(i)}];
      end else if (!tx_busy_ff && tx_busy_q && CTS) begin
        tx_sh_ff   <= {1'b1, tx_q_ff[tx_qi_ff[2:0]], 1'b0};
        tx_busy_ff <= 1'b1;
        tx_bit_ff  <= 4'h0;
        tx_cnt_ff  <= 16'(BIT_CYCLES - 1);
        tx_qi_ff   <= tx_qi_ff + 4'h1;
      end else if (tx_busy_ff) begin
        if (tx_cnt_ff != 16'h0000) tx_cnt_ff <= tx_cnt_ff - 16'h0001;
        else begin
          tx_cnt_ff <= 16'(BIT_CYCLES - 1);
          tx_sh_ff  <= {1'b1, tx_sh_ff[9:1]};
          tx_bit_ff <= tx_bit_ff + 4'h1;
          if (tx_bit_ff == 4'(DATA_BITS + STOP_BITS)) tx_busy_ff <= 1'b0;
        end
      end
    end
  end
  assign TXD = tx_sh_ff[0];
endmodule

// >>> logic/mon_mailbox_pkg.sv
package mon_mailbox_pkg;
  // Clock and serial timing
  localparam int CLK_HZ        = 125000000;
  localparam int BAUD          = 9600;
  localparam int BIT_CYCLES    = CLK_HZ / BAUD;
  localparam int HALF_CYCLES   = BIT_CYCLES / 2;
  localparam int DATA_BITS     = 8;
  localparam int STOP_BITS     = 1;
  // Command codes
  localparam logic [7:0] CMD_MBOX_WR = 8'h4E;
  localparam logic [7:0] CMD_MBOX_RD = 8'h4F;
  localparam logic [7:0] CMD_SPAD_WR = 8'h52;
  localparam logic [7:0] CMD_SPAD_RD = 8'h53;
  // Mailbox values
  localparam logic [7:0] MBOX_IDLE   = 8'h00;
  localparam logic [7:0] MBOX_ATTN   = 8'h01;
  localparam logic [7:0] MBOX_ACK    = 8'h02;
  localparam logic [7:0] MBOX_INQ    = 8'h03;
  localparam logic [7:0] MBOX_WRITE  = 8'h04;
  localparam logic [7:0] MBOX_NAK    = 8'h05;
  localparam logic [7:0] MBOX_EOS    = 8'h06;
  // Scratchpad geometry
  localparam int SPAD_BLOCKS     = 32;
  localparam int SPAD_BLOCK_BYTES = 8;
  localparam int PAYLOAD_BYTES   = 32;
  localparam logic [7:0] BLOCK_MAX = 8'h1F;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_type;

  typedef enum logic [2:0] {
    CP_IDLE = 3'b000,
    CP_MBWR = 3'b001,
    CP_BLK  = 3'b010,
    CP_SWR  = 3'b011,
    CP_RESP = 3'b100
  } cmd_state_type;
endpackage

// >>> bench/mon_mailbox_chk.sv
`timescale 1ns/100ps
module mon_mailbox_chk
  import mon_mailbox_pkg::*;
(
  input wire logic                      CLK,
  input wire logic                      SRST,
  input wire logic                      CE,
  input wire logic                      CMD_WR,
  input wire logic                      DATA_WR,
  input wire logic [7:0]                HOST_WDATA,
  input wire logic                      CMD_CONSUMED,
  input wire logic                      DATA_CONSUMED,
  input wire mon_mailbox_pkg::byte_type HOST_RESP,
  input wire logic                      TXD,
  input wire logic                      DCD,
  input wire logic                      RING,
  input wire logic                      DIAL_REQ,
  input wire logic                      DIAL_ALLOWED,
  input wire logic                      ANSWER,
  input wire logic [7:0]                MAILBOX
);
  logic [7:0] cmd_ff;
  logic [7:0] wd_ff;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // Last command seen, so a data byte can be tied to its command
  always_ff @(posedge CLK) begin
    if (CE && CMD_WR) begin
      cmd_ff <= HOST_WDATA;
    end
  end
  // Last data byte, the value a mailbox write must leave behind
  always_ff @(posedge CLK) begin
    if (CE && DATA_WR) begin
      wd_ff <= HOST_WDATA;
    end
  end
  property p_rst;
    disable iff (1'b0) SRST && CE |=> MAILBOX == MBOX_IDLE && TXD && !ANSWER;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_rd;
    CE && CMD_WR && HOST_WDATA == CMD_MBOX_RD |=> !CMD_CONSUMED ##1
      (CMD_CONSUMED && HOST_RESP.valid && HOST_RESP.data == MAILBOX);
  endproperty
  a_rd: assert property (p_rd) else $error("mailbox read reply wrong");
  property p_keep;
    CE && CMD_WR && HOST_WDATA == CMD_MBOX_RD |=> $stable(MAILBOX) [*2];
  endproperty
  a_keep: assert property (p_keep) else $error("read changed mailbox");
  property p_wr;
    CE && DATA_WR && cmd_ff == CMD_MBOX_WR |-> ##[1:3] MAILBOX == wd_ff;
  endproperty
  a_wr: assert property (p_wr) else $error("mailbox write lost");
  property p_cmd;
    CE && CMD_WR |=> !CMD_CONSUMED ##[1:2] CMD_CONSUMED;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command flag wrong");
  property p_dat;
    CE && DATA_WR |=> !DATA_CONSUMED ##[1:2] DATA_CONSUMED;
  endproperty
  a_dat: assert property (p_dat) else $error("data flag wrong");
  property p_dial;
    DIAL_ALLOWED == (DIAL_REQ && !DCD);
  endproperty
  a_dial: assert property (p_dial) else $error("dial gating wrong");
  property p_ring;
    CE && RING |=> ANSWER;
  endproperty
  a_ring: assert property (p_ring) else $error("call not answered");
  property p_frz;
    !CE |=> $stable(MAILBOX) && $stable(ANSWER) && $stable(CMD_CONSUMED) && $stable(DATA_CONSUMED);
  endproperty
  a_frz: assert property (p_frz) else $error("state moved while frozen");
  c_rd: cover property (CE && CMD_WR && HOST_WDATA == CMD_MBOX_RD);
  c_spad: cover property (CE && DATA_WR && cmd_ff == CMD_SPAD_WR);
  c_call: cover property (ANSWER && DCD);
endmodule
bind monitor_mailbox_serial_link mon_mailbox_chk i_chk (.CLK(CLK), .SRST(SRST), .CE(CE), .CMD_WR(CMD_WR),
  .DATA_WR(DATA_WR), .HOST_WDATA(HOST_WDATA), .CMD_CONSUMED(CMD_CONSUMED), .DATA_CONSUMED(DATA_CONSUMED),
  .HOST_RESP(HOST_RESP), .TXD(TXD), .DCD(DCD), .RING(RING), .DIAL_REQ(DIAL_REQ),
  .DIAL_ALLOWED(DIAL_ALLOWED), .ANSWER(ANSWER), .MAILBOX(MAILBOX));

// >>> bench/remote_modem.sv
`timescale 1ns/100ps
module remote_modem (
  input  wire logic clk,
  input  wire logic call,
  input  wire logic rts,
  input  wire logic answer,
  output logic      rxd,
  output logic      cts,
  output logic      dcd,
  output logic      ring
);
  logic connected_ff = 1'b0;
  // A frame lasts far longer than the run, so the far end stays idle high
  assign rxd = 1'b1;
  // Modem accepts data only while the monitor says it is ready
  assign cts = rts;
  // Carrier strictly follows a live connection, never stuck on
  assign dcd = connected_ff;
  assign ring = call && !connected_ff;
  // Connection made once the monitor answers, dropped when the caller leaves
  always @(posedge clk) begin
    connected_ff <= call && (connected_ff || answer);
  end
endmodule

// >>> bench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import mon_mailbox_pkg::*;
  logic       CLK, SRST, CE, CMD_WR, DATA_WR, HOST_RD, DIAL_REQ, call;
  logic       CMD_CONSUMED, DATA_CONSUMED, RXD, TXD, CTS, RTS, DCD, RING, DIAL_ALLOWED, ANSWER;
  logic [7:0] HOST_WDATA, MAILBOX, rnd, v;
  byte_type   HOST_RESP;
  int         error_cnt = 0;
  int         comparisons = 0;
  logic [7:0] mbox;
  logic [7:0] spad [4][8];
  logic [7:0] blk [4] = '{8'h00, BLOCK_MAX, 8'h0E, 8'h10};
  monitor_mailbox_serial_link i_monitor_mailbox_serial_link (.CLK(CLK), .SRST(SRST), .CE(CE), .CMD_WR(CMD_WR),
    .DATA_WR(DATA_WR), .HOST_WDATA(HOST_WDATA), .HOST_RD(HOST_RD), .CMD_CONSUMED(CMD_CONSUMED),
    .DATA_CONSUMED(DATA_CONSUMED), .HOST_RESP(HOST_RESP), .RXD(RXD), .TXD(TXD), .CTS(CTS), .RTS(RTS),
    .DCD(DCD), .RING(RING), .DIAL_REQ(DIAL_REQ), .DIAL_ALLOWED(DIAL_ALLOWED), .ANSWER(ANSWER), .MAILBOX(MAILBOX));
  remote_modem i_remote_modem (.clk(CLK), .call(call), .rts(RTS), .answer(ANSWER), .rxd(RXD), .cts(CTS),
    .dcd(DCD), .ring(RING));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic end_of_test;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait on a handshake level; a hang ends the run
  task automatic wait_for(input int sel);
    for (int n = 0; n < 64; n++) begin
      @(negedge CLK);
      if ((sel == 0 && CMD_CONSUMED === 1'b1) || (sel == 1 && DATA_CONSUMED === 1'b1) ||
          (sel == 2 && HOST_RESP.valid === 1'b1) || (sel == 3 && ANSWER === 1'b1)) begin
        return;
      end
    end
    error_cnt++;
    $display("FAIL wait %0d timed out", sel);
    end_of_test();
  endtask
  // One host byte; the extra edge lets the consumed flag drop first
  task automatic put(input logic cmd, input logic [7:0] b);
    wait_for(cmd ? 0 : 1);
    CMD_WR = cmd;
    DATA_WR = !cmd;
    HOST_WDATA = b;
    @(negedge CLK);
    CMD_WR = 1'b0;
    DATA_WR = 1'b0;
    @(negedge CLK);
  endtask
  task automatic rd_resp(input logic [7:0] exp);
    wait_for(2);
    chk("resp", exp, HOST_RESP.data);
    HOST_RD = 1'b1;
    @(negedge CLK);
    HOST_RD = 1'b0;
    @(negedge CLK);
  endtask
  task automatic rd_mbox;
    put(1'b1, CMD_MBOX_RD);
    rd_resp(mbox);
    chk("mailbox", mbox, MAILBOX);
  endtask
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // Inputs move at falling edges only
  initial begin
    {SRST, CE, DIAL_REQ} = 3'b111;
    {CMD_WR, DATA_WR, HOST_RD, call} = 4'h0;
    HOST_WDATA = 8'h00;
    rnd = 8'h21;
    mbox = MBOX_IDLE;
    repeat (8) @(negedge CLK);
    SRST = 1'b0;
    chk("mailbox", MBOX_IDLE, MAILBOX);
    chk("line idle", 8'h03, {6'h00, TXD, RTS});
    rd_mbox();
    // Every defined code, then random bytes, each read back twice
    for (int i = 0; i < 15; i++) begin
      v = (i < 7) ? 8'(i) : rnd;
      // Random private codes stay clear of the reserved ranges
      if (i >= 7 && (v < 8'h20 || v >= 8'hF0)) v = v ^ 8'h80;
      rnd = lfsr(rnd);
      put(1'b1, CMD_MBOX_WR);
      put(1'b0, v);
      mbox = v;
      rd_mbox();
      rd_mbox();
      // Polling driver sees attention or inquiry and answers with acknowledge
      if (v == MBOX_ATTN || v == MBOX_INQ) begin
        put(1'b1, CMD_MBOX_WR);
        put(1'b0, MBOX_ACK);
        mbox = MBOX_ACK;
        rd_mbox();
      end
    end
    // Unknown command leaves the mailbox alone
    put(1'b1, 8'h45);
    rd_mbox();
    // One 32-byte payload in four blocks, read back through numbers that wrap onto them
    for (int b = 0; b < PAYLOAD_BYTES / SPAD_BLOCK_BYTES; b++) begin
      put(1'b1, CMD_SPAD_WR);
      put(1'b0, blk[b]);
      for (int i = 0; i < SPAD_BLOCK_BYTES; i++) begin
        spad[b][i] = rnd;
        rnd = lfsr(rnd);
        put(1'b0, spad[b][i]);
      end
    end
    for (int b = PAYLOAD_BYTES / SPAD_BLOCK_BYTES - 1; b >= 0; b--) begin
      put(1'b1, CMD_SPAD_RD);
      put(1'b0, blk[b] | 8'h20);
      for (int i = 0; i < SPAD_BLOCK_BYTES; i++) begin
        rd_resp(spad[b][i]);
      end
    end
    // Frozen clock enable holds everything
    CE = 1'b0;
    CMD_WR = 1'b1;
    HOST_WDATA = CMD_MBOX_WR;
    @(negedge CLK);
    CMD_WR = 1'b0;
    repeat (20) @(negedge CLK);
    chk("frozen", mbox, MAILBOX);
    chk("frozen flag", 8'h01, {7'h00, CMD_CONSUMED});
    CE = 1'b1;
    // Incoming call is answered and carrier then blocks dialling
    call = 1'b1;
    wait_for(3);
    repeat (3) @(negedge CLK);
    chk("carrier", 8'h01, {7'h00, DCD});
    chk("dial", 8'h00, {7'h00, DIAL_ALLOWED});
    call = 1'b0;
    repeat (3) @(negedge CLK);
    chk("dial", 8'h01, {7'h00, DIAL_ALLOWED});
    DIAL_REQ = 1'b0;
    @(negedge CLK);
    chk("dial", 8'h00, {7'h00, DIAL_ALLOWED});
    DIAL_REQ = 1'b1;
    // Second reset in mid-run returns to idle
    SRST = 1'b1;
    repeat (2) @(negedge CLK);
    SRST = 1'b0;
    mbox = MBOX_IDLE;
    rd_mbox();
    end_of_test();
  end
endmodule
